// ### hdl/rdc_top.sv
// Purpose: Executes the restart and target reinitialize commands.
// Assumes: Companion logic (flush, queue, selection, interrupter) is on ref_clk.
// Notes: Software loads the parameter block over APB and writes go.
`timescale 1ns/1ns
`default_nettype none
`include "rdc_regs.svh"

// Overview of operation
// - Restart resets both SCSI ports first
// - Then flush internal commands except restart
// - Then rewind command queue read pointer
// - Finally post completion to response block
// - Restart keeps init and queue parameters
// - Code 0x4B decodes as restart
// - Code 0x4C decodes as target reinitialize
// - Options bit 0 enables completion interrupt
// - Low byte error vector, high normal
// - Level bits 0-2; 0 needs interrupts off
// - Status word 0x2: zero success, else error
// - Reinitialize clears target negotiation state
// - Cleared target renegotiates on next selection
// - Unit address lives at word 0xF
// - Normal addressing: bits 0-2 target id
// - Normal addressing: bits 3-5 logical unit
// - Bit 6 selects primary or secondary port
// - Bit 7 selects normal or extended format
// - Extended addressing: bits 0-4 target id
// - Extended addressing: bits 8-13 logical unit
module rdc_top (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [1:0] scsiPortRst,
	output logic flushReq,
	input wire logic flushAck,
	input wire logic cqAdvance,
	output logic [3:0] cqPtr,
	input wire logic selValid,
	input wire logic selChan,
	input wire logic [4:0] selId,
	output logic negValid,
	output logic negNeeded,
	output rdc_pkg::rdc_irq_t irqOut,
	input wire logic irqAck,
	output logic busy
);
	import rdc_pkg::*;

	// Port reset hold in cycles, rounded up so a pulse is never short.
	localparam logic [8:0] PRST_CYC = 9'(`RDC_PRST_CYC);

	logic [15:0] cmd_reg;
	logic [15:0] opt_reg;
	logic [15:0] stat_reg;
	logic [15:0] vec_reg;
	logic [15:0] lvl_reg;
	logic [15:0] unit_reg;
	rdc_state_t state_reg;
	rdc_state_t state_next;
	logic [8:0] hold_reg;
	logic [63:0] neg_reg;
	logic [31:0] prdata_next;
	logic [4:0] wordIdx;
	logic mapped;
	logic apbWr;
	logic goStart;
	logic isRestart;
	logic isReinit;
	logic lvlBad;
	logic irqOn;
	logic [15:0] status_next;
	rdc_unit_t unit;
	logic [5:0] tgtIdx;
	logic [5:0] selIdx;

	// Word index of the access; a misaligned or out of range address errs.
	assign wordIdx = paddr[6:2];
	assign mapped = (paddr[1:0] == 2'h0) && !paddr[7]
		&& (wordIdx <= `RDC_W_LAST);
	assign apbWr = psel && penable && pwrite && mapped;
	assign goStart = apbWr && (wordIdx == `RDC_W_GO) && pwdata[0];
	// No wait states: each access completes in its first access cycle.
	assign pready = 1'b1;
	assign busy = (state_reg != SIdle);

	// Command decode from the first block word.
	assign isRestart = (cmd_reg == `RDC_CODE_RESTART);
	assign isReinit = (cmd_reg == `RDC_CODE_REINIT);
	// Level 0 may not be used while the completion interrupt is enabled.
	assign lvlBad = opt_reg[`RDC_OPT_IEN] && (lvl_reg[2:0] == 3'h0);
	// The interrupt is used only when enabled on a legal level, so a
	// rejected level-0 request never reaches the bus interrupter.
	assign irqOn = opt_reg[`RDC_OPT_IEN] && !lvlBad;

	// Unit address decode in both addressing formats.
	always_comb begin
		unit.ext = unit_reg[`RDC_UA_EXT];
		unit.chan = unit_reg[`RDC_UA_CHAN];
		if (unit.ext) begin
			unit.id = unit_reg[4:0];
			unit.lun = unit_reg[13:8];
		end else begin
			unit.id = {2'h0, unit_reg[2:0]};
			unit.lun = {3'h0, unit_reg[5:3]};
		end
	end
	// Bit index into the negotiation map: channel then target id.
	assign tgtIdx = {unit.chan, unit.id};
	assign selIdx = {selChan, selId};

	// Outcome of a command, chosen before any action is taken.
	// A bad code is reported ahead of a bad level.
	always_comb begin
		if (!isRestart && !isReinit) begin
			status_next = `RDC_ST_BADCMD;
		end else if (lvlBad) begin
			status_next = `RDC_ST_BADLVL;
		end else begin
			status_next = `RDC_ST_OK;
		end
	end

	// Block words are writable only while idle so a running command
	// never sees its parameters change under it.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cmd_reg <= 16'h0000;
			opt_reg <= 16'h0000;
			vec_reg <= 16'h0000;
			lvl_reg <= 16'h0000;
			unit_reg <= 16'h0000;
		end else if (apbWr && !busy) begin
			unique case (wordIdx)
				`RDC_W_CMD: cmd_reg <= pwdata[15:0];
				`RDC_W_OPT: opt_reg <= pwdata[15:0];
				`RDC_W_VEC: vec_reg <= pwdata[15:0];
				`RDC_W_LVL: lvl_reg <= pwdata[15:0];
				`RDC_W_UNIT: unit_reg <= pwdata[15:0];
				default: ;
			endcase
		end
	end

	// Sequencer next state. A restart walks port reset, flush, rewind and
	// post in that order; a reinitialize clears one map bit; any error
	// skips every action and goes straight to posting.
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			SIdle: begin
				if (goStart) begin
					state_next = SCheck;
				end
			end
			SCheck: begin
				if (status_next != `RDC_ST_OK) begin
					state_next = SPost;
				end else if (isRestart) begin
					state_next = SPortRst;
				end else begin
					state_next = SClrNeg;
				end
			end
			SPortRst: begin
				if (hold_reg == 9'h000) begin
					state_next = SFlush;
				end
			end
			SFlush: begin
				if (flushAck) begin
					state_next = SRewind;
				end
			end
			SRewind: state_next = SPost;
			SClrNeg: state_next = SPost;
			SPost: begin
				if (irqOn) begin
					state_next = SIrq;
				end else begin
					state_next = SIdle;
				end
			end
			SIrq: begin
				if (irqAck) begin
					state_next = SIdle;
				end
			end
		endcase
	end

	// Sequencer state register.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= SIdle;
		end else begin
			state_reg <= state_next;
		end
	end

	// Port reset: both ports held for the minimum reset time.
	// The counter is loaded on entry, so the count starts with the pulse.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			hold_reg <= 9'h000;
			scsiPortRst <= 2'h0;
		end else if (state_reg == SCheck && state_next == SPortRst) begin
			hold_reg <= PRST_CYC - 9'h001;
			scsiPortRst <= 2'h3;
		end else if (state_reg == SPortRst && hold_reg != 9'h000) begin
			hold_reg <= hold_reg - 9'h001;
		end else begin
			scsiPortRst <= 2'h0;
		end
	end

	// Flush request to the command store; the store spares the restart.
	// The request is a level that stands until the store acknowledges,
	// so a slow store only stretches the flush step.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			flushReq <= 1'b0;
		end else begin
			flushReq <= (state_next == SFlush);
		end
	end

	// Command queue read pointer; a restart returns it to the base.
	// Restart touches only this pointer, not init or queue parameters.
	// An advance in the rewind cycle is dropped so the rewind wins.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cqPtr <= `RDC_CQ_BASE;
		end else if (state_reg == SRewind) begin
			cqPtr <= `RDC_CQ_BASE;
		end else if (cqAdvance) begin
			cqPtr <= cqPtr + 4'h1;
		end
	end

	// Negotiation map: a bit set means the target already negotiated.
	// One entry per channel and target id, indexed {chan, id}.
	// A selection setting a bit wins over a clear in the same cycle,
	// so a handshake that just happened is never forgotten.
	for (genvar gi = 0; gi < 64; gi++) begin : gNeg
		// One entry of the map.
		always_ff @(posedge ref_clk or negedge nrst) begin
			if (!nrst) begin
				neg_reg[gi] <= 1'b0;
			end else if (selValid && selIdx == 6'(gi)) begin
				neg_reg[gi] <= 1'b1;
			end else if (state_reg == SClrNeg && tgtIdx == 6'(gi)) begin
				neg_reg[gi] <= 1'b0;
			end
		end
	end

	// Answer to a selection: renegotiate when the target's bit is clear.
	// The answer reads the map before this selection's own update lands.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			negValid <= 1'b0;
			negNeeded <= 1'b0;
		end else begin
			negValid <= selValid;
			negNeeded <= selValid && !neg_reg[selIdx];
		end
	end

	// Return status is captured at the end of the check step, so it is
	// in place before posting and before any interrupt.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			stat_reg <= `RDC_ST_OK;
		end else if (state_reg == SCheck) begin
			stat_reg <= status_next;
		end
	end

	// Completion interrupt, raised only after the status is in place,
	// with the vector picked by outcome; held until acknowledged.
	// Level and vector are kept after release; only the request drops.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			irqOut <= '0;
		end else if (state_reg == SPost && irqOn) begin
			irqOut.req <= 1'b1;
			irqOut.level <= lvl_reg[2:0];
			if (stat_reg == `RDC_ST_OK) begin
				irqOut.vector <= vec_reg[15:8];
			end else begin
				irqOut.vector <= vec_reg[7:0];
			end
		end else if (state_reg == SIrq && irqAck) begin
			irqOut.req <= 1'b0;
		end
	end

	// Read mux; reserved words and upper bits read as zero.
	// The state word packs the interrupt, sequencer state and busy flag.
	always_comb begin
		prdata_next = 32'h0;
		unique case (wordIdx)
			`RDC_W_CMD: prdata_next = {16'h0, cmd_reg};
			`RDC_W_OPT: prdata_next = {16'h0, opt_reg};
			`RDC_W_STAT: prdata_next = {16'h0, stat_reg};
			`RDC_W_VEC: prdata_next = {16'h0, vec_reg};
			`RDC_W_LVL: prdata_next = {16'h0, lvl_reg};
			`RDC_W_UNIT: prdata_next = {16'h0, unit_reg};
			`RDC_W_STATE: prdata_next = {27'h0, irqOut.req,
				state_reg, busy};
			`RDC_W_CQPTR: prdata_next = {28'h0, cqPtr};
			`RDC_W_NEGLO: prdata_next = neg_reg[31:0];
			`RDC_W_NEGHI: prdata_next = neg_reg[63:32];
			`RDC_W_TGT: prdata_next = {19'h0, unit.ext, unit.lun,
				unit.chan, unit.id};
			default: prdata_next = 32'h0;
		endcase
	end

	// Read data and error are captured in the setup cycle.
	// Capturing early keeps both from flops, stable through the access.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			prdata <= mapped ? prdata_next : 32'h0;
			pslverr <= !mapped;
		end
	end

endmodule
`default_nettype wire

// ### hdl/rdc_regs.svh
// Purpose: Offsets, field positions, codes and timing for the restart block.
// Assumes: Byte address of a block word is four times its word index.
// Notes: Definitions only.
`ifndef RDC_REGS_SVH
`define RDC_REGS_SVH
// Parameter block word indices.
`define RDC_W_CMD 5'h00
`define RDC_W_OPT 5'h01
`define RDC_W_STAT 5'h02
`define RDC_W_VEC 5'h04
`define RDC_W_LVL 5'h05
`define RDC_W_UNIT 5'h0f
// Control words beyond the block.
`define RDC_W_GO 5'h18
`define RDC_W_STATE 5'h19
`define RDC_W_CQPTR 5'h1a
`define RDC_W_NEGLO 5'h1b
`define RDC_W_NEGHI 5'h1c
`define RDC_W_TGT 5'h1d
`define RDC_W_LAST 5'h1d
// Command codes.
`define RDC_CODE_RESTART 16'h004b
`define RDC_CODE_REINIT 16'h004c
// Field positions.
`define RDC_OPT_IEN 0
`define RDC_UA_CHAN 6
`define RDC_UA_EXT 7
// Return status values.
`define RDC_ST_OK 16'h0000
`define RDC_ST_BADCMD 16'h0001
`define RDC_ST_BADLVL 16'h0002
// Reset values.
`define RDC_CQ_BASE 4'h0
// Port reset hold time and the cycles it takes at 100 ns a cycle.
`define RDC_CLK_NS 100
`define RDC_PRST_NS 25000
`define RDC_PRST_CYC ((`RDC_PRST_NS + `RDC_CLK_NS - 1) / `RDC_CLK_NS)
`endif

// ### hdl/rdc_pkg.sv
// Purpose: Types shared by the restart and reinitialize block.
// Assumes: Constants come from rdc_regs.svh.
// Notes: Types only.
package rdc_pkg;
	// Sequencer states.
	typedef enum logic [2:0] {
		SIdle, SCheck, SPortRst, SFlush, SRewind, SClrNeg, SPost, SIrq
	} rdc_state_t;
	// Completion interrupt request toward the bus interrupter.
	typedef struct packed {
		logic req;
		logic [2:0] level;
		logic [7:0] vector;
	} rdc_irq_t;
	// Decoded unit address.
	typedef struct packed {
		logic chan;
		logic [4:0] id;
		logic [5:0] lun;
		logic ext;
	} rdc_unit_t;
endpackage

// ### sim/rdc_assertions.sv
// Purpose: Port checks for the restart and reinitialize block.
// Assumes: One clock domain on ref_clk.
// Notes: Bound to rdc_top at the foot of this file.
`timescale 1ns/1ns
`default_nettype none
module rdc_assertions (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [1:0] scsiPortRst,
	input wire logic flushReq,
	input wire logic flushAck,
	input wire logic cqAdvance,
	input wire logic [3:0] cqPtr,
	input wire logic selValid,
	input wire logic negValid,
	input wire logic negNeeded,
	input wire rdc_pkg::rdc_irq_t irqOut,
	input wire logic irqAck,
	input wire logic busy
);
	import rdc_pkg::*;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);
	logic [8:0] rstCnt;
	// Counts the cycles that the port reset has stood.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			rstCnt <= 9'h000;
		else
			rstCnt <= scsiPortRst[0] ? rstCnt + 9'h001 : 9'h000;
	end
	a_both_ports: assert property (scsiPortRst != 2'h0 |-> scsiPortRst == 2'h3)
		else $error("port resets not paired");
	a_reset_len: assert property ($fell(scsiPortRst[0]) |-> rstCnt == 9'h0fa)
		else $error("port reset length wrong");
	a_flush_next: assert property ($fell(scsiPortRst[0]) |-> ##[0:2] flushReq)
		else $error("no flush after port reset");
	a_flush_hold: assert property (flushReq && !flushAck |=> flushReq)
		else $error("flush dropped early");
	a_queue_rewind: assert property (flushReq && flushAck |-> ##[1:3] cqPtr == 4'h0)
		else $error("queue pointer not rewound");
	a_queue_step: assert property (cqAdvance && !busy |=> cqPtr == $past(cqPtr) + 4'h1)
		else $error("queue pointer did not step");
	a_irq_hold: assert property (irqOut.req && !irqAck |=> irqOut.req)
		else $error("interrupt dropped before ack");
	a_irq_clear: assert property (irqOut.req && irqAck |=> !irqOut.req)
		else $error("interrupt stuck after ack");
	a_irq_busy: assert property (irqOut.req |-> busy)
		else $error("interrupt outside command");
	a_neg_timing: assert property (negValid == $past(selValid))
		else $error("selection answer mistimed");
	a_irq_level: assert property (irqOut.req |-> irqOut.level != 3'h0)
		else $error("interrupt at level zero");
	// Main scenarios reached.
	c_irq: cover property ($rose(irqOut.req));
	c_flush: cover property ($fell(flushReq));
	c_reneg: cover property (negValid && negNeeded);
endmodule
bind rdc_top rdc_assertions rdc_assertions_inst (.ref_clk, .nrst, .scsiPortRst,
	.flushReq, .flushAck, .cqAdvance, .cqPtr, .selValid, .negValid, .negNeeded,
	.irqOut, .irqAck, .busy);
`default_nettype wire

// ### sim/rdc_partner.sv
// Purpose: Far side: internal command store and host interrupt handler.
// Assumes: lat is at least one cycle.
// Notes: Each acknowledge is a single-cycle pulse.
`timescale 1ns/1ns
`default_nettype none
module rdc_partner (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [2:0] lat,
	input wire logic flushReq,
	input wire logic irqReq,
	output logic flushAck,
	output logic irqAck
);
	int fc, ic;
	// The store discards all but the running restart, then acknowledges.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			fc <= 0;
			flushAck <= 1'b0;
		end else begin
			fc <= flushReq ? fc + 1 : 0;
			flushAck <= flushReq && fc == lat;
		end
	end
	// The host services the interrupt after lat cycles.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ic <= 0;
			irqAck <= 1'b0;
		end else begin
			ic <= irqReq ? ic + 1 : 0;
			irqAck <= irqReq && ic == lat;
		end
	end
endmodule
`default_nettype wire

// ### sim/restart_and_device_reinit_cmds_test.sv
// Purpose: Self-checking bench for the restart and reinitialize block.
// Assumes: The slave answers each access; waits are bounded.
// Notes: A model tracks status, vectors and negotiation state.
`timescale 1ns/1ns
`default_nettype none
`include "rdc_regs.svh"
module restart_and_device_reinit_cmds_test;
	import rdc_pkg::*;
	logic ref_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rdata;
	logic pready, pslverr, rerr, flushReq, flushAck, cqAdvance = 0, busy;
	logic selValid = 0, selChan = 0, negValid, negNeeded, irqAck;
	logic [4:0] selId = 0;
	logic [3:0] cqPtr;
	logic [1:0] scsiPortRst;
	logic [2:0] lat = 1;
	rdc_irq_t irqOut, got;
	int nErrors = 0, nCompared = 0, negd[64], seen;
	rdc_top rdc_top_inst (.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .scsiPortRst, .flushReq,
		.flushAck, .cqAdvance, .cqPtr, .selValid, .selChan, .selId, .negValid,
		.negNeeded, .irqOut, .irqAck, .busy);
	rdc_partner rdc_partner_inst (.ref_clk, .nrst, .lat, .flushReq,
		.irqReq(irqOut.req), .flushAck, .irqAck);
	// Free-running clock.
	initial forever #50 ref_clk = ~ref_clk;
	// Prints the counts and the verdict, then stops.
	task finishTest();
		$display("errors %0d compared %0d", nErrors, nCompared);
		if (nErrors == 0 && nCompared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Compares one value against the model.
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		nCompared++;
		if (g !== e) begin
			nErrors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Ends the run when a wait used up its bound.
	task tmo(input bit ok);
		if (!ok) begin
			nErrors++;
			$display("[FAIL] wait expected done seen timeout");
			finishTest();
		end
	endtask
	// One APB transfer; read data and error land in rdata and rerr.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge ref_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		i = 0;
		do begin
			@(posedge ref_clk);
			i++;
		end while (pready !== 1 && i < 50);
		tmo(pready === 1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// Selects a target and checks the renegotiation answer.
	task sel(input logic c, input logic [4:0] id);
		@(posedge ref_clk);
		selValid <= 1;
		selChan <= c;
		selId <= id;
		@(posedge ref_clk);
		selValid <= 0;
		@(posedge ref_clk);
		chk("negValid", 1, negValid);
		chk("negNeeded", !negd[{c, id}], negNeeded);
		negd[{c, id}] = 1;
	endtask
	// Loads a parameter block, starts it and checks the completion.
	task run(input logic [15:0] cmd, opt, vec, lvl, ua, st);
		int i, rc, fc, re, fb;
		bit rs, ien;
		lat <= 3'(1 + $urandom % 6);
		apb(1, 8'h00, cmd);
		apb(1, 8'h04, opt);
		apb(1, 8'h10, vec);
		apb(1, 8'h14, lvl);
		apb(1, 8'h3c, ua);
		apb(1, 8'h60, 1);
		// Only a good restart resets the ports and flushes; only an
		// enabled interrupt on a legal level is raised.
		rs = (cmd == `RDC_CODE_RESTART) && (st == `RDC_ST_OK);
		ien = opt[0] && (lvl[2:0] != 3'h0);
		seen = 0;
		rc = 0;
		fc = 0;
		re = 0;
		fb = 0;
		i = 0;
		do begin
			@(posedge ref_clk);
			i++;
			if (irqOut.req === 1 && seen == 0) begin
				seen = 1;
				got = irqOut;
			end
			if (scsiPortRst === 2'h3) begin
				rc++;
				re = i;
			end
			if (flushReq === 1) begin
				if (fc == 0)
					fb = i;
				fc++;
			end
		end while (busy !== 0 && i < 1000);
		tmo(busy === 0);
		apb(0, 8'h08, 0);
		chk("status", st, rdata);
		chk("portRstCycles", rs ? `RDC_PRST_CYC : 0, rc);
		chk("flushSeen", rs, fc != 0);
		chk("flushAfterReset", rs, rs && fb > re);
		chk("irq", ien, seen);
		if (seen) begin
			chk("level", lvl[2:0], got.level);
			chk("vector", st == 0 ? vec[15:8] : vec[7:0], got.vector);
		end
	endtask
	// Main sequence.
	initial begin
		int k, n;
		logic [15:0] ua;
		logic c;
		logic [4:0] id;
		void'($urandom(32'h63b1f0a6));
		repeat (12) @(posedge ref_clk);
		nrst <= 1;
		apb(0, 8'hfc, 0);
		chk("pslverr", 1, rerr);
		chk("prdata", 0, rdata);
		for (k = 0; k < 6; k++) begin
			ua = $urandom & (k[0] ? 16'h3fdf : 16'h007f);
			ua[7] = k[0];
			c = ua[6];
			id = k[0] ? ua[4:0] : {2'b00, ua[2:0]};
			sel(c, id);
			run(16'h004c, 16'(k < 3), $urandom, 1 + $urandom % 7, ua, 0);
			negd[{c, id}] = 0;
			apb(0, 8'h74, 0);
			chk("target", {ua[7], k[0] ? ua[13:8] : {3'b0, ua[5:3]}, c, id}, rdata);
			sel(c, id);
		end
		n = 1 + $urandom % 9;
		repeat (n) begin
			@(posedge ref_clk);
			cqAdvance <= 1;
			@(posedge ref_clk);
			cqAdvance <= 0;
		end
		apb(0, 8'h68, 0);
		chk("cqPtr", n, rdata);
		run(16'h004b, 1, $urandom, 1 + $urandom % 7, 0, 0);
		chk("cqPtr", 0, cqPtr);
		sel(c, id);
		run(16'h004d, 1, $urandom, 1 + $urandom % 7, 0, 1);
		run(16'h004b, 0, $urandom, 1 + $urandom % 7, 0, 0);
		run(16'h004c, 1, $urandom, 0, ua, `RDC_ST_BADLVL);
		sel(c, id);
		finishTest();
	end
endmodule
`default_nettype wire
